// file: hw/gated_frequency_counter.v
// Gated frequency counter: gate timing, prescaler, BCD counter, display latch and decoder.
// Assumes sigIn and both selector switches are asynchronous pins, conditioned to logic levels.
`default_nettype none
`include "freq_counter_defines.vh"

module gated_frequency_counter #(
	parameter integer GATE_SHORT_CYCLES = `REF_CLK_HZ / `MS_PER_S * `GATE_SHORT_MS,
	parameter integer GATE_LONG_CYCLES  = `REF_CLK_HZ / `MS_PER_S * `GATE_LONG_MS
) (
	input  wire          ref_clk,
	input  wire          rst_n,
	input  wire          sigIn,
	input  wire          gateLongSel,
	input  wire          highBandSel,
	output wire          gateOpen,
	output wire          latchStrobe,
	output wire          counterClear,
	output wire          gateLed,
	output wire [55:0]   segOut
);

	localparam [`TIMER_W-1:0] SHORT_LEN = GATE_SHORT_CYCLES[`TIMER_W-1:0];
	localparam [`TIMER_W-1:0] LONG_LEN  = GATE_LONG_CYCLES[`TIMER_W-1:0];

	reg                 sigSync1_q;
	reg                 sigSync2_q;
	reg                 sigPrev_q;
	reg                 longSync1_q;
	reg                 longSync2_q;
	reg                 highSync1_q;
	reg                 highSync2_q;
	reg  [`ST_W-1:0]    state_q;
	reg  [`TIMER_W-1:0] timer_q;
	reg  [`TIMER_W-1:0] gateLen_q;
	reg                 longGate_q;
	reg                 highBand_q;
	reg                 gateLed_q;
	reg  [3:0]          prescale_q;
	reg  [`BCD_W-1:0]   count_q;
	reg  [`BCD_W-1:0]   count_d;
	reg  [`BCD_W-1:0]   disp_q;
	reg                 dispShort_q;
	reg  [`SEGS_W-1:0]  seg_q;
	reg  [`SEGS_W-1:0]  seg_d;
	reg  [`BCD_W-1:0]   shown;
	reg                 carry;
	reg                 lead;
	integer             i;
	integer             j;

	wire                sigEdge;
	wire                prescaleTick;
	wire                countPulse;
	wire                gateEnd;

	// Two-stage synchronisers; the edge detector reads the second stage and its delayed copy sigPrev_q
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			sigSync1_q  <= 1'b0;
			sigSync2_q  <= 1'b0;
			sigPrev_q   <= 1'b0;
			longSync1_q <= 1'b0;
			longSync2_q <= 1'b0;
			highSync1_q <= 1'b0;
			highSync2_q <= 1'b0;
		end else begin
			sigSync1_q  <= sigIn;
			sigSync2_q  <= sigSync1_q;
			sigPrev_q   <= sigSync2_q;
			longSync1_q <= gateLongSel;
			longSync2_q <= longSync1_q;
			highSync1_q <= highBandSel;
			highSync2_q <= highSync1_q;
		end
	end

	// Pulses faster than half the reference rate cannot be resolved here
	assign sigEdge      = sigSync2_q & ~sigPrev_q;
	assign prescaleTick = sigEdge & (prescale_q == `PRESCALE_LAST);

	assign gateOpen     = (state_q == `ST_OPEN);
	assign latchStrobe  = (state_q == `ST_LATCH);
	assign counterClear = (state_q == `ST_CLEAR);
	assign gateEnd      = gateOpen & (timer_q == gateLen_q - 1'b1);
	assign countPulse   = gateOpen & (highBand_q ? prescaleTick : sigEdge);
	assign gateLed      = gateLed_q;
	assign segOut       = seg_q;

	// Gate sequencer: open for one period, one latch cycle, one clear cycle
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q    <= `ST_CLEAR;
			timer_q    <= {`TIMER_W{1'b0}};
			gateLen_q  <= SHORT_LEN;
			longGate_q <= 1'b0;
			highBand_q <= 1'b0;
			gateLed_q  <= 1'b0;
		end else begin
			case (state_q)
				`ST_OPEN: begin
					if (gateEnd) begin
						state_q <= `ST_LATCH;
						timer_q <= {`TIMER_W{1'b0}};
					end else begin
						timer_q <= timer_q + 1'b1;
					end
					gateLed_q <= (timer_q < (gateLen_q >> 1)) & ~gateEnd;
				end
				`ST_LATCH: begin
					state_q   <= `ST_CLEAR;
					gateLed_q <= 1'b0;
				end
				`ST_CLEAR: begin
					// Switches are taken only between periods so a period is never mixed
					state_q    <= `ST_OPEN;
					longGate_q <= longSync2_q;
					highBand_q <= highSync2_q;
					gateLen_q  <= longSync2_q ? LONG_LEN : SHORT_LEN;
					timer_q    <= {`TIMER_W{1'b0}};
					gateLed_q  <= 1'b0;
				end
				default: begin
					state_q   <= `ST_CLEAR;
					gateLed_q <= 1'b0;
				end
			endcase
		end
	end

	// Divide-by-ten prescaler, restarted every period for a repeatable count
	always @(posedge ref_clk) begin
		if (!rst_n || counterClear) begin
			prescale_q <= `BCD_ZERO;
		end else if (sigEdge) begin
			if (prescale_q == `PRESCALE_LAST)
				prescale_q <= `BCD_ZERO;
			else
				prescale_q <= prescale_q + 1'b1;
		end
	end

	// Ripple-carry decimal increment over eight digits; wraps past 99999999
	always @* begin
		count_d = count_q;
		carry   = countPulse;
		for (i = 0; i < `DIGITS; i = i + 1) begin
			if (carry) begin
				if (count_q[i*4 +: 4] == `BCD_NINE) begin
					count_d[i*4 +: 4] = `BCD_ZERO;
				end else begin
					count_d[i*4 +: 4] = count_q[i*4 +: 4] + `BCD_ONE;
					carry = 1'b0;
				end
			end
		end
	end

	always @(posedge ref_clk) begin
		if (!rst_n || counterClear)
			count_q <= {`BCD_W{1'b0}};
		else
			count_q <= count_d;
	end

	// Display latch holds the last result through the whole next period
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			disp_q      <= {`BCD_W{1'b0}};
			dispShort_q <= 1'b0;
		end else if (latchStrobe) begin
			disp_q      <= count_q;
			dispShort_q <= ~longGate_q;
		end
	end

	function [`SEG_W-1:0] segOf;
		input [3:0] digit;
		begin
			case (digit)
				4'h0: segOf = `SEG_0;
				4'h1: segOf = `SEG_1;
				4'h2: segOf = `SEG_2;
				4'h3: segOf = `SEG_3;
				4'h4: segOf = `SEG_4;
				4'h5: segOf = `SEG_5;
				4'h6: segOf = `SEG_6;
				4'h7: segOf = `SEG_7;
				4'h8: segOf = `SEG_8;
				4'h9: segOf = `SEG_9;
				default: segOf = `SEG_OFF;
			endcase
		end
	endfunction

	// A short-gate count of 100000 or more means the input is above 1 MHz
	always @* begin
		if (dispShort_q && (disp_q[`BCD_W-1:`MHZ_DIGIT_LSB] != {(`BCD_W-`MHZ_DIGIT_LSB){1'b0}}))
			shown = disp_q >> 4;
		else
			shown = disp_q;
		seg_d = {`SEGS_W{1'b0}};
		lead  = 1'b1;
		for (j = `DIGITS - 1; j > 0; j = j - 1) begin
			lead = lead & (shown[j*4 +: 4] == `BCD_ZERO);
			seg_d[j*`SEG_W +: `SEG_W] = lead ? `SEG_OFF : segOf(shown[j*4 +: 4]);
		end
		// Last digit is never blanked, so an idle input reads 0
		seg_d[`SEG_W-1:0] = segOf(shown[3:0]);
	end

	always @(posedge ref_clk) begin
		if (!rst_n)
			seg_q <= {`SEGS_W{1'b0}};
		else
			seg_q <= seg_d;
	end

endmodule // gated_frequency_counter

`default_nettype wire

// file: pkg/freq_counter_defines.vh
// Constants for the gated frequency counter: timing, states, digit layout, segment patterns.
// Assumes a 25 MHz reference clock and active-high segment outputs in gfedcba order.
//
// How it works
// - Gate period comes from dividing the reference clock; 0.1 s or 1 s selectable.
// - Gate indicator blinks once per gate period: 1/s long, 10/s short.
// - High-frequency path divides the incoming pulse train by ten before counting.
// - Each measurement opens the gate for exactly one period; pulses pass only then.
// - Counter adds one per pulse seen during the open gate and holds the total.
// - Gate closure blocks pulses and moves the count into the display latch.
// - Display latch shows the previous result until the next period ends.
// - Gate timing also produces the latch strobe and the counter reset.
// - Every leading zero digit of the shown value except the last digit is blanked.
// - Below 1 MHz the raw count in hertz is shown; tenth of frequency on 0.1 s.
// - Above 1 MHz on the 0.1 s gate (10 MHz on the high-frequency path) the least significant digit is dropped.
// - Eight seven-segment digits; no input shows only 0 on the last digit.
`ifndef FREQ_COUNTER_DEFINES_VH
`define FREQ_COUNTER_DEFINES_VH

`define REF_CLK_HZ      25000000
`define MS_PER_S        1000
`define GATE_SHORT_MS   100
`define GATE_LONG_MS    1000
`define TIMER_W         25

`define ST_W            2
`define ST_OPEN         2'h0
`define ST_LATCH        2'h1
`define ST_CLEAR        2'h2

`define DIGITS          8
`define BCD_W           32
`define SEG_W           7
`define SEGS_W          56
`define PRESCALE_LAST   4'h9
`define BCD_NINE        4'h9
`define BCD_ZERO        4'h0
`define BCD_ONE         4'h1
`define MHZ_DIGIT_LSB   20

`define SEG_0           7'h3F
`define SEG_1           7'h06
`define SEG_2           7'h5B
`define SEG_3           7'h4F
`define SEG_4           7'h66
`define SEG_5           7'h6D
`define SEG_6           7'h7D
`define SEG_7           7'h07
`define SEG_8           7'h7F
`define SEG_9           7'h6F
`define SEG_OFF         7'h00

`endif

// file: dv/gfc_assertions.sv
// Checker for gate sequencing, display hold and blanking.
// Assumes binding to gated_frequency_counter with its gate lengths.
`default_nettype none
module gfc_assertions #(
	parameter integer GATE_SHORT_CYCLES = 20,
	parameter integer GATE_LONG_CYCLES  = 200
) (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        gateOpen,
	input wire logic        latchStrobe,
	input wire logic        counterClear,
	input wire logic        gateLed,
	input wire logic [55:0] segOut
);
	timeunit 1ns;
	timeprecision 1ns;
	int openLen_q;
	always @(posedge ref_clk) openLen_q <= (!rst_n || !gateOpen) ? 0 : openLen_q + 1;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence closeSeq;
		latchStrobe ##1 (counterClear && !gateOpen) ##1 gateOpen;
	endsequence
	AST_CLOSE_ORDER: assert property ($fell(gateOpen) |-> closeSeq)
		else $error("gate close order broken");
	AST_GATE_LEN: assert property ($fell(gateOpen) |->
		openLen_q == GATE_SHORT_CYCLES || openLen_q == GATE_LONG_CYCLES) else $error("gate length");
	AST_OPEN_MAX: assert property (openLen_q <= GATE_LONG_CYCLES)
		else $error("gate open too long");
	AST_STROBE_ONE: assert property (latchStrobe |=> !latchStrobe && counterClear)
		else $error("strobe not one cycle");
	AST_CLEAR_ONE: assert property (counterClear |=> !counterClear && gateOpen)
		else $error("clear not one cycle");
	AST_SEG_HOLD: assert property ($past(rst_n) && !$past(latchStrobe) &&
		!$past(counterClear) |-> $stable(segOut)) else $error("display moved mid period");
	AST_LED_ON: assert property ($rose(gateOpen) |-> ##[0:2] gateLed)
		else $error("gate led missing");
	AST_LED_OFF: assert property (latchStrobe |-> !gateLed)
		else $error("gate led stuck");
	AST_LOW_LIT: assert property ($past(rst_n) |-> segOut[6:0] != 7'h00)
		else $error("last digit dark");
	AST_TOP_BLANK: assert property (segOut[55:49] != 7'h3F)
		else $error("leading zero lit");
endmodule // gfc_assertions
`default_nettype wire

// file: dv/pulse_source.sv
// Signal source model: square wave with programmable half period.
// Assumes the bench enables it; a silent source leaves the line low.
`default_nettype none
module pulse_source (
	input  wire logic       ref_clk,
	input  wire logic       en,
	input  wire logic [7:0] halfCyc,
	output var  logic       sigIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt;
	initial sigIn = 1'b0;
	always @(posedge ref_clk) begin
		if (!en) begin
			sigIn <= #2 1'b0;
			cnt <= 8'h00;
		end else if (cnt == halfCyc - 8'h01) begin
			sigIn <= #2 !sigIn;
			cnt <= 8'h00;
		end else
			cnt <= cnt + 8'h01;
	end
endmodule // pulse_source
`default_nettype wire

// file: dv/tb.sv
// Bench: feeds the counter from the source model and checks the display.
// Assumes gate lengths shortened to 20 and 200 cycles.
`default_nettype none
`define CHK(nm, exp, got) begin nTests++; if ((got) !== (exp)) begin errTotal++; \
	$display("wrong value %s exp %h got %h", nm, exp, got); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SHORT = 20;
	localparam int LONG = 200;
	logic        ref_clk, rst_n, sigIn, gateLongSel, highBandSel, srcEn;
	logic        gateOpen, latchStrobe, counterClear, gateLed;
	logic [55:0] segOut;
	logic [7:0]  halfCyc;
	int          errTotal, nTests;
	logic [6:0]  segTab [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
		7'h7F, 7'h6F};
	gated_frequency_counter #(.GATE_SHORT_CYCLES(SHORT), .GATE_LONG_CYCLES(LONG))
	gated_frequency_counter_inst (.ref_clk(ref_clk), .rst_n(rst_n), .sigIn(sigIn),
		.gateLongSel(gateLongSel), .highBandSel(highBandSel), .gateOpen(gateOpen),
		.latchStrobe(latchStrobe), .counterClear(counterClear), .gateLed(gateLed),
		.segOut(segOut));
	pulse_source pulse_source_inst (.ref_clk(ref_clk), .en(srcEn), .halfCyc(halfCyc),
		.sigIn(sigIn));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	function automatic logic [55:0] expSeg(input int v);
		logic [55:0] s;
		s = '0;
		for (int k = 0; k < 8; k++) begin
			if (k == 0 || v > 0) s[7*k+:7] = segTab[v % 10];
			v = v / 10;
		end
		return s;
	endfunction
	task automatic giveVerdict();
		$display("checks %0d errors %0d", nTests, errTotal);
		if (errTotal == 0 && nTests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic doReset();
		rst_n = 1'b0;
		repeat (6) @(posedge ref_clk);
		#2 rst_n = 1'b1;
	endtask
	task automatic waitLatch();
		int i;
		@(posedge ref_clk) #2;
		for (i = 0; i < 400 && latchStrobe !== 1'b1; i++) @(posedge ref_clk) #2;
		if (i == 400) begin
			errTotal++;
			giveVerdict();
		end
	endtask
	// Second close ends the first period wholly under the new settings; the check follows the third
	task automatic measure(input logic lng, hb, input logic [7:0] half, input int expv);
		{gateLongSel, highBandSel, halfCyc, srcEn} = {lng, hb, half, half != 8'h00};
		repeat (3) waitLatch();
		repeat (2) @(posedge ref_clk);
		#2 `CHK("segOut", expSeg(expv), segOut)
	endtask
	task automatic scnIdle();
		measure(1'b0, 1'b0, 8'h00, 0);
	endtask
	task automatic scnShort();
		measure(1'b0, 1'b0, 8'h02, SHORT / 4);
	endtask
	task automatic scnLong();
		measure(1'b1, 1'b0, 8'h02, LONG / 4);
	endtask
	task automatic scnPrescale();
		measure(1'b1, 1'b1, 8'h02, LONG / 40);
	endtask
	task automatic scnSlow();
		measure(1'b1, 1'b0, 8'h05, LONG / 10);
	endtask
	initial begin
		{rst_n, gateLongSel, highBandSel, srcEn, halfCyc} = '0;
		errTotal = 0;
		nTests = 0;
		doReset();
		scnIdle();
		scnShort();
		scnLong();
		scnPrescale();
		doReset();
		scnSlow();
		giveVerdict();
	end
endmodule // tb
bind gated_frequency_counter gfc_assertions #(.GATE_SHORT_CYCLES(GATE_SHORT_CYCLES),
	.GATE_LONG_CYCLES(GATE_LONG_CYCLES)) gfc_assertions_inst (.ref_clk(ref_clk),
	.rst_n(rst_n), .gateOpen(gateOpen), .latchStrobe(latchStrobe),
	.counterClear(counterClear), .gateLed(gateLed), .segOut(segOut));
`default_nettype wire
